// [clock_guard_pkg.sv]
/*
 Shared constants and types of the clock guard: register offset, field positions,
 reset values, timing counts and the state records.
 Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package clock_guard_pkg;
	localparam int CLK_PERIOD_NS = 4;
	// Longest tolerated gap between main oscillator edges
	localparam int LOSS_TIME_NS = 200;
	localparam int LOSS_CYCLES = LOSS_TIME_NS / CLK_PERIOD_NS;
	localparam logic [7:0] LOSS_LIMIT = 8'(LOSS_CYCLES - 1);
	// Clean edges counted while lost; the next edge after these marks the main source recovered
	localparam logic [1:0] RECOVER_EDGES = 2'h3;

	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] STATUS_CONTROL_OFS = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int WATCHDOG_RESET_BIT = 0;
	localparam int CLOCK_LOSS_BIT = 1;
	localparam int CLOCK_LOSS_IE_BIT = 2;
	localparam int LOW_VOLTAGE_RESET_BIT = 4;
	localparam int SUPPLY_WARNING_BIT = 5;
	localparam int SUPPLY_WARNING_IE_BIT = 6;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	typedef struct packed {
		logic wait_mode;
		logic halt_mode;
	} power_mode_t;

	typedef struct packed {
		logic supervision_enable;
		logic low_voltage_enable;
		logic multiplier_enable;
	} option_t;

	typedef struct packed {
		logic prev;
		logic filt;
		logic filt_prev;
		logic [7:0] gap_cnt;
		logic [1:0] edge_cnt;
		logic lost;
	} monitor_state_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_full;
		logic aw_hit;
		logic w_full;
		logic [7:0] w_byte;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic supply_ie;
		logic clock_ie;
		logic supply_flag;
		logic low_volt_flag;
		logic wdg_flag;
		logic clock_flag;
		logic supply_pend;
		logic safe_sel;
		logic safe_osc_en;
		logic clock_irq;
		logic supply_irq;
		logic wake;
	} guard_state_t;
endpackage

// [clock_guard_monitor.sv]
/*
 Main oscillator monitor: optional spike filter and loss / recovery detector.
 Assumes the oscillator arrives as a level sampled synchronously to aclk.
*/
`timescale 1ns/1ns
module clock_guard_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic filter_enable,
	input wire logic osc_sample,
	output logic osc_filtered,
	output logic osc_lost
);
	clock_guard_pkg::monitor_state_t s_q;
	clock_guard_pkg::monitor_state_t s_d;
	logic edge_seen;

	assign edge_seen = s_q.filt != s_q.filt_prev;
	assign osc_filtered = s_q.filt;
	assign osc_lost = s_q.lost;

	always_comb begin
		s_d = s_q;
		s_d.prev = osc_sample;
		s_d.filt_prev = s_q.filt;
		// A one-sample spike never reaches the output while filtering
		if (!filter_enable || osc_sample == s_q.prev) begin
			s_d.filt = osc_sample;
		end
		if (edge_seen) begin
			s_d.gap_cnt = 8'h00;
		end else if (s_q.gap_cnt != clock_guard_pkg::LOSS_LIMIT) begin
			s_d.gap_cnt = s_q.gap_cnt + 8'h01;
		end
		if (!edge_seen && s_q.gap_cnt == clock_guard_pkg::LOSS_LIMIT) begin
			s_d.lost = 1'b1;
			s_d.edge_cnt = 2'h0;
		end else if (s_q.lost && edge_seen) begin
			if (s_q.edge_cnt == clock_guard_pkg::RECOVER_EDGES) begin
				s_d.lost = 1'b0;
			end else begin
				s_d.edge_cnt = s_q.edge_cnt + 2'h1;
			end
		end
		if (!enable) begin
			s_d = '0;
			s_d.prev = osc_sample;
			s_d.filt = osc_sample;
			s_d.filt_prev = osc_sample;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	default clocking mcb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	spike_filter_a: assert property (filter_enable && enable && osc_sample != s_q.prev |=> $stable(s_q.filt))
		else $error("spike passed the filter");
endmodule

// [clock_guard.sv]
/*
 System integrity clock guard: clock supervision, supply warning, reset source
 flags and their status/control register behind an AXI4-Lite slave.
 Assumes synchronous inputs, one outstanding write and read, and a reset
 manager that pulses the reset source events during or after aresetn.
*/
`timescale 1ns/1ns
// Contract
// - Filter oscillator spikes only with multiplier on
// - Lost main clock switches core to safe
// - Recovered main clock switches back automatically
// - Clock-loss flag bit 1 set while safe
// - Status read clears clock-loss after recovery
// - Supervision disabled holds clock-loss flag low
// - Clock-loss enable bit 2, ignored when disabled
// - Interrupts need enable and cleared global mask
// - Wake from wait, never from halt
// - Halt freezes register, stops supervision; reset events and supervision off still change flags
// - Halt exit keeps configuration, reset restores
// - Supply enable bit 6, pending on toggle
// - Supply flag bit 5, hysteresis, read-only
// - Low-voltage flag bit 4, write zero clears
// - Watchdog flag bit 0, cleared by low-voltage
// - Low-voltage flag survives later resets
// - Reset reads zero except source flags
// - Supply comparator works only with detection
module clock_guard (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire clock_guard_pkg::option_t options,
	input wire clock_guard_pkg::power_mode_t power_mode,
	input wire logic main_oscillator_clock,
	input wire logic supply_below_lower,
	input wire logic supply_above_upper,
	input wire logic low_voltage_reset_event,
	input wire logic watchdog_reset_event,
	input wire logic global_irq_mask,
	input wire logic supply_irq_serviced,
	output logic core_clock_from_safe,
	output logic safe_oscillator_enable,
	output logic main_oscillator_filtered,
	output logic clock_loss_irq,
	output logic supply_warning_irq,
	output logic wake_request
);
	clock_guard_pkg::guard_state_t s_q;
	clock_guard_pkg::guard_state_t s_d;
	logic mon_lost;
	logic mon_filt;
	logic halted;
	logic watch_on;
	logic [7:0] status_now;
	logic wr_fire;
	logic rd_fire;
	logic rd_hit;
	logic [7:0] wr_mask;

	function automatic logic addr_hit(input logic [7:0] addr);
		addr_hit = addr[7:2] == clock_guard_pkg::STATUS_CONTROL_OFS[7:2];
	endfunction

	function automatic logic [7:0] status_byte(input clock_guard_pkg::guard_state_t s);
		logic [7:0] b;
		b = clock_guard_pkg::STATUS_RESET;
		b[clock_guard_pkg::SUPPLY_WARNING_IE_BIT] = s.supply_ie;
		b[clock_guard_pkg::SUPPLY_WARNING_BIT] = s.supply_flag;
		b[clock_guard_pkg::LOW_VOLTAGE_RESET_BIT] = s.low_volt_flag;
		b[clock_guard_pkg::CLOCK_LOSS_IE_BIT] = s.clock_ie;
		b[clock_guard_pkg::CLOCK_LOSS_BIT] = s.clock_flag;
		b[clock_guard_pkg::WATCHDOG_RESET_BIT] = s.wdg_flag;
		status_byte = b;
	endfunction

	assign halted = power_mode.halt_mode;
	// Supervision and safe oscillator are off during halt
	assign watch_on = options.supervision_enable && !halted;
	assign status_now = status_byte(s_q);
	assign wr_fire = s_q.aw_full && s_q.w_full && !s_q.bvalid;
	assign rd_fire = s_axi_arvalid && s_q.arready;
	assign rd_hit = addr_hit(s_axi_araddr);
	assign wr_mask = s_q.w_byte;

	clock_guard_monitor monitor (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(watch_on),
		.filter_enable(options.multiplier_enable),
		.osc_sample(main_oscillator_clock),
		.osc_filtered(mon_filt),
		.osc_lost(mon_lost)
	);

	always_comb begin
		s_d = s_q;
		// Write address and data are taken independently, in either order
		if (s_axi_awvalid && s_q.awready) begin
			s_d.aw_full = 1'b1;
			s_d.aw_hit = addr_hit(s_axi_awaddr);
		end
		if (s_axi_wvalid && s_q.wready) begin
			s_d.w_full = 1'b1;
			s_d.w_byte = s_axi_wdata[7:0];
			s_d.w_lane0 = s_axi_wstrb[0];
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		// Register writes take effect only outside halt
		if (wr_fire) begin
			s_d.aw_full = 1'b0;
			s_d.w_full = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = s_q.aw_hit ? clock_guard_pkg::RESP_OKAY : clock_guard_pkg::RESP_SLVERR;
			if (s_q.aw_hit && s_q.w_lane0 && !halted) begin
				s_d.supply_ie = wr_mask[clock_guard_pkg::SUPPLY_WARNING_IE_BIT];
				s_d.clock_ie = wr_mask[clock_guard_pkg::CLOCK_LOSS_IE_BIT];
				// Only a zero clears a reset source flag, a one keeps it
				if (!wr_mask[clock_guard_pkg::LOW_VOLTAGE_RESET_BIT]) begin
					s_d.low_volt_flag = 1'b0;
				end
				if (!wr_mask[clock_guard_pkg::WATCHDOG_RESET_BIT]) begin
					s_d.wdg_flag = 1'b0;
				end
			end
		end
		s_d.awready = !s_d.aw_full && !s_d.bvalid;
		s_d.wready = !s_d.w_full && !s_d.bvalid;

		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (rd_fire) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_hit ? status_byte(s_q) : 8'h00;
			s_d.rresp = rd_hit ? clock_guard_pkg::RESP_OKAY : clock_guard_pkg::RESP_SLVERR;
		end
		s_d.arready = !s_d.rvalid;

		if (!halted) begin
			// Reading clears the flag only once the main source is back; setting wins
			if (rd_fire && rd_hit && !mon_lost) begin
				s_d.clock_flag = 1'b0;
			end
			if (mon_lost) begin
				s_d.clock_flag = 1'b1;
			end
			if (!options.low_voltage_enable) begin
				s_d.supply_flag = 1'b0;
			end else if (supply_below_lower) begin
				s_d.supply_flag = 1'b1;
			end else if (supply_above_upper) begin
				s_d.supply_flag = 1'b0;
			end
			if (supply_irq_serviced) begin
				s_d.supply_pend = 1'b0;
			end
			if (s_d.supply_flag != s_q.supply_flag && s_q.supply_ie) begin
				s_d.supply_pend = 1'b1;
			end
		end
		if (!options.supervision_enable) begin
			s_d.clock_flag = 1'b0;
		end
		// The main source returns by itself once the monitor sees clean edges
		s_d.safe_sel = watch_on && mon_lost;
		s_d.safe_osc_en = watch_on && mon_lost;
		s_d.clock_irq = s_q.clock_flag && s_q.clock_ie && options.supervision_enable && !global_irq_mask;
		s_d.supply_irq = s_q.supply_pend && !global_irq_mask;
		// Both events wake from wait only
		s_d.wake = power_mode.wait_mode && !halted && (s_d.clock_irq || s_d.supply_irq);

		if (low_voltage_reset_event) begin
			s_d.low_volt_flag = 1'b1;
			s_d.wdg_flag = 1'b0;
		end else if (watchdog_reset_event) begin
			s_d.wdg_flag = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Configuration restarts from reset values; reset source flags survive
			s_q <= '0;
			s_q.awready <= 1'b1;
			s_q.wready <= 1'b1;
			s_q.arready <= 1'b1;
			s_q.low_volt_flag <= s_d.low_volt_flag;
			s_q.wdg_flag <= s_d.wdg_flag;
		end else begin
			// Halt exit by interrupt keeps everything held during halt
			s_q <= s_d;
		end
	end

	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rdata = {24'h000000, s_q.rdata};
	assign s_axi_rresp = s_q.rresp;
	assign s_axi_rvalid = s_q.rvalid;
	assign core_clock_from_safe = s_q.safe_sel;
	assign safe_oscillator_enable = s_q.safe_osc_en;
	assign main_oscillator_filtered = mon_filt;
	assign clock_loss_irq = s_q.clock_irq;
	assign supply_warning_irq = s_q.supply_irq;
	assign wake_request = s_q.wake;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	safe_switch_a: assert property (watch_on && mon_lost |=> core_clock_from_safe && safe_oscillator_enable)
		else $error("safe oscillator not selected on loss");
	switch_back_a: assert property (!mon_lost |=> !core_clock_from_safe)
		else $error("core clock stayed on safe oscillator");
	loss_flag_set_a: assert property (watch_on && mon_lost |=> status_now[clock_guard_pkg::CLOCK_LOSS_BIT])
		else $error("clock-loss flag not set");
	read_clear_a: assert property (watch_on && rd_fire && rd_hit && !mon_lost |=> !s_q.clock_flag)
		else $error("clock-loss flag not cleared by read");
	watch_off_flag_a: assert property (!options.supervision_enable |=> !s_q.clock_flag ##1 !clock_loss_irq)
		else $error("clock-loss flag set with supervision off");
	loss_irq_gate_a: assert property (s_q.clock_flag && s_q.clock_ie && options.supervision_enable
		&& !global_irq_mask |=> clock_loss_irq)
		else $error("clock-loss interrupt missing");
	mask_blocks_a: assert property (global_irq_mask |=> !clock_loss_irq && !supply_warning_irq)
		else $error("interrupt passed the global mask");
	halt_no_wake_a: assert property (power_mode.halt_mode |=> !wake_request)
		else $error("wake request during halt");
	halt_frozen_a: assert property (power_mode.halt_mode && !low_voltage_reset_event && !watchdog_reset_event
		|=> status_byte(s_q) == $past(status_byte(s_q)))
		else $error("status changed during halt");
	supply_pend_a: assert property (!halted && s_q.supply_ie && $changed(s_q.supply_flag) |-> s_q.supply_pend)
		else $error("supply toggle left no pending request");
	supply_below_a: assert property (!halted && options.low_voltage_enable && supply_below_lower
		|=> s_q.supply_flag)
		else $error("supply flag not set below threshold");
	low_volt_wdg_a: assert property (low_voltage_reset_event |=> s_q.low_volt_flag && !s_q.wdg_flag)
		else $error("low-voltage reset did not update source flags");
	write_one_keep_a: assert property (wr_fire && s_q.aw_hit && s_q.w_lane0 && wr_mask[4] && wr_mask[0]
		&& !low_voltage_reset_event && !watchdog_reset_event
		|=> s_q.low_volt_flag == $past(s_q.low_volt_flag) && s_q.wdg_flag == $past(s_q.wdg_flag))
		else $error("writing one changed a reset source flag");
	write_resp_a: assert property (wr_fire |=> s_axi_bvalid)
		else $error("write response missing");
endmodule

// [osc_irq_partner.sv]
/*
 Far-side model: main oscillator source with spike injection, and the
 interrupt controller's service pulse. Assumes inputs change after aclk edges.
*/
`timescale 1ns/1ns
module osc_irq_partner (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic spike,
	input wire logic irq,
	output logic osc,
	output logic serviced
);
	logic [1:0] cnt_q;
	logic lvl_q;
	logic spk_q;
	logic seen_q;
	assign osc = lvl_q ^ spk_q;
	always_ff @(posedge aclk) begin
		spk_q <= spike;
		seen_q <= irq;
		// Service routine entered once for each new request
		serviced <= aresetn & irq & ~seen_q;
		if (!aresetn) begin
			cnt_q <= 2'h0;
			lvl_q <= 1'b0;
		end else if (run) begin
			cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
			if (cnt_q == 2'h2) begin
				lvl_q <= ~lvl_q;
			end
		end
	end
endmodule

// [tb_top.sv]
/*
 Testbench of the clock guard: AXI4-Lite register sequences and pin checks.
 Assumes the oscillator/interrupt partner model and a 250 MHz clock.
*/
`timescale 1ns/1ns
module tb_top;
	localparam logic [1:0] OK = clock_guard_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = clock_guard_pkg::RESP_SLVERR;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, osc, below, above, lv_evt, wd_evt;
	logic mask, svc, safe, safe_en, filt, cirq, sirq, wake, run, spike, v;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [3:0] wstrb;
	clock_guard_pkg::option_t opts;
	clock_guard_pkg::power_mode_t pm;
	int n_errors = 0;
	int checked = 0;

	clock_guard u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .options(opts),
		.power_mode(pm), .main_oscillator_clock(osc), .supply_below_lower(below),
		.supply_above_upper(above), .low_voltage_reset_event(lv_evt), .watchdog_reset_event(wd_evt),
		.global_irq_mask(mask), .supply_irq_serviced(svc), .core_clock_from_safe(safe),
		.safe_oscillator_enable(safe_en), .main_oscillator_filtered(filt), .clock_loss_irq(cirq),
		.supply_warning_irq(sirq), .wake_request(wake));

	osc_irq_partner u_partner (.aclk(aclk), .aresetn(aresetn), .run(run), .spike(spike), .irq(sirq),
		.osc(osc), .serviced(svc));

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	task automatic stop_test();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic timeout(input string nm);
		n_errors++;
		$display("mismatch %s expected answer seen timeout", nm);
		stop_test();
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				break;
			end
		end
		if (n == 40) begin
			timeout("write");
		end
		bready <= 1'b0;
		check("bresp", 32'(bresp), 32'(er));
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
			end
			if (rvalid) begin
				break;
			end
		end
		if (n == 40) begin
			timeout("read");
		end
		rready <= 1'b0;
		check("rdata", rdata, {24'h0, d});
		check("rresp", 32'(rresp), 32'(er));
	endtask

	function automatic logic pick(input int k);
		case (k)
			0: return safe;
			1: return cirq;
			2: return sirq;
			3: return wake;
			default: return filt;
		endcase
	endfunction

	task automatic wait_for(input int k, input logic lv);
		int n;
		for (n = 0; n < 300; n++) begin
			@(posedge aclk);
			if (pick(k) === lv) begin
				checked++;
				return;
			end
		end
		timeout("level");
	endtask

	task automatic hold(input int k, input logic lv, input int c);
		repeat (c) begin
			@(posedge aclk);
			check("steady level", 32'(pick(k)), 32'(lv));
		end
	endtask

	task automatic evt(input logic l);
		@(posedge aclk);
		lv_evt <= l;
		wd_evt <= ~l;
		@(posedge aclk);
		lv_evt <= 1'b0;
		wd_evt <= 1'b0;
	endtask

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, below, wd_evt, mask, spike} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		{above, lv_evt, run} = 3'h7;
		opts = 3'h6;
		pm = 2'h0;
		@(posedge aclk);
		lv_evt <= 1'b0;
		repeat (7) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h00, 8'h10, OK);
		wr(8'h00, 8'h77, OK);
		rd(8'h00, 8'h54, OK);
		evt(1'b0);
		rd(8'h00, 8'h55, OK);
		wr(8'h00, 8'h44, OK);
		rd(8'h00, 8'h44, OK);
		evt(1'b0);
		evt(1'b1);
		rd(8'h00, 8'h54, OK);
		wr(8'h40, 8'h00, ERR);
		rd(8'h40, 8'h00, ERR);
		rd(8'h00, 8'h54, OK);
		wstrb <= 4'h0;
		wr(8'h00, 8'h00, OK);
		wstrb <= 4'hF;
		rd(8'h00, 8'h54, OK);
		below <= 1'b1;
		above <= 1'b0;
		wait_for(2, 1'b1);
		wait_for(2, 1'b0);
		rd(8'h00, 8'h74, OK);
		wr(8'h00, 8'h54, OK);
		rd(8'h00, 8'h74, OK);
		mask <= 1'b1;
		below <= 1'b0;
		above <= 1'b1;
		hold(2, 1'b0, 10);
		mask <= 1'b0;
		wait_for(2, 1'b1);
		wait_for(2, 1'b0);
		opts.low_voltage_enable <= 1'b0;
		below <= 1'b1;
		above <= 1'b0;
		rd(8'h00, 8'h54, OK);
		below <= 1'b0;
		above <= 1'b1;
		@(posedge aclk);
		opts.low_voltage_enable <= 1'b1;
		run <= 1'b0;
		wait_for(0, 1'b1);
		check("safe_en", 32'(safe_en), 32'h1);
		wait_for(1, 1'b1);
		mask <= 1'b1;
		wait_for(1, 1'b0);
		mask <= 1'b0;
		rd(8'h00, 8'h56, OK);
		rd(8'h00, 8'h56, OK);
		run <= 1'b1;
		wait_for(0, 1'b0);
		rd(8'h00, 8'h56, OK);
		rd(8'h00, 8'h54, OK);
		pm <= 2'h2;
		run <= 1'b0;
		wait_for(3, 1'b1);
		pm <= 2'h3;
		wait_for(0, 1'b0);
		check("safe_en", 32'(safe_en), 32'h0);
		hold(3, 1'b0, 5);
		wr(8'h00, 8'h00, OK);
		run <= 1'b1;
		pm <= 2'h0;
		rd(8'h00, 8'h56, OK);
		rd(8'h00, 8'h54, OK);
		opts.supervision_enable <= 1'b0;
		run <= 1'b0;
		hold(0, 1'b0, 80);
		check("clock irq", 32'(cirq), 32'h0);
		rd(8'h00, 8'h54, OK);
		run <= 1'b1;
		opts.supervision_enable <= 1'b1;
		opts.multiplier_enable <= 1'b1;
		repeat (20) @(posedge aclk);
		run <= 1'b0;
		repeat (10) @(posedge aclk);
		v = filt;
		spike <= 1'b1;
		@(posedge aclk);
		spike <= 1'b0;
		hold(4, v, 6);
		opts.multiplier_enable <= 1'b0;
		repeat (10) @(posedge aclk);
		v = filt;
		spike <= 1'b1;
		@(posedge aclk);
		spike <= 1'b0;
		wait_for(4, ~v);
		stop_test();
	end
endmodule
